// [inc/frr_pkg.sv]
/*
  frr_pkg: constants, register offsets, field positions and reset values for the
  front-end readout and capacitive sensor register bank.
  Assumes: 32-bit APB, 8-bit registers in the low byte of each aligned word.
*/
package frr_pkg;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] IDX_REGULATOR_READOUT     = 8'h2C;
  localparam logic [7:0] IDX_SIGNAL_STRENGTH_PEAKS = 8'h2D;
  localparam logic [7:0] IDX_GAIN_REDUCTION_STATE  = 8'h2E;
  localparam logic [7:0] IDX_CAP_SENSOR_CONTROL    = 8'h2F;
  localparam logic [7:0] IDX_CAP_SENSOR_RESULT     = 8'h30;
  localparam logic [7:0] IDX_REGULATOR_CONTROL     = 8'h40;
  localparam logic [7:0] IDX_STRENGTH_COMMAND      = 8'h41;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int REG_CODE_LSB   = 4;
  localparam int REG_ILIM_BIT   = 0;
  localparam int AM_LSB         = 4;
  localparam int PM_LSB         = 0;
  localparam int TRIM_LSB       = 3;
  localparam int GAIN_LSB       = 0;
  localparam int CAL_END_BIT    = 2;
  localparam int CAL_ERR_BIT    = 1;
  localparam int REG_MODE_BIT   = 7;
  localparam int REG_EXT_LSB    = 3;
  localparam int CLEAR_CMD_BIT  = 0;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] CAP_CONTROL_RESET = 8'h00;
  localparam logic [7:0] REG_CONTROL_RESET = 8'h00;
  localparam logic [3:0] CODE_RESET        = 4'h0;
  localparam logic [4:0] TRIM_AUTO         = 5'h00;

  // sensor gain codes
  localparam logic [2:0] GAIN_2P8  = 3'h0;
  localparam logic [2:0] GAIN_6P5  = 3'h1;
  localparam logic [2:0] GAIN_1P1  = 3'h2;
  localparam logic [2:0] GAIN_0P5  = 3'h4;
  localparam logic [2:0] GAIN_0P35 = 3'h6;

endpackage

// [verilog/frr_peak_hold.sv]
/*
  frr_peak_hold: one channel's peak signal-strength holder.
  Assumes: strength codes are monotonic in amplitude, sample_valid marks a fresh sample,
  rx_start and clear are one-cycle pulses from the command decoder.
*/
module frr_peak_hold #(
  parameter int W = 4
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         rx_start,
  input  wire logic         clear,
  input  wire logic         sample_valid,
  input  wire logic [W-1:0] sample,
  output logic      [W-1:0] peak
);

  // a holder narrower than one bit cannot carry a code
  if (W < 1) begin : g_bad_w
    $error("frr_peak_hold: W must be at least 1");
  end

  typedef struct packed {
    logic [W-1:0] peak;
  } frr_peak_state_t;

  frr_peak_state_t st;
  frr_peak_state_t next_st;

  // restart or clear drops the held peak; a sample in that cycle still counts
  always_comb begin
    logic [W-1:0] base;
    base = st.peak;
    if (rx_start || clear) begin
      base = '0;
    end
    next_st.peak = base;
    if (sample_valid && (sample > base)) begin
      next_st.peak = sample;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign peak = st.peak;

endmodule

// [verilog/frr_regs.sv]
/*
  frr_regs: APB register bank reporting regulator setting, signal-strength peaks,
  gain reduction and capacitive sensor calibration; holds sensor and regulator control.
  Assumes: analog and command logic drive the status inputs synchronous to pclk.
*/
//
// Contract
// - regulator code in readout bits 7..4; they show the last adjust result, not the software code
// - bit 0 shows current-limit condition
// - code maps to 0.1 V voltage steps
// - AM peak held in bits 7..4
// - PM peak held in bits 3..0
// - strength codes are monotonic logarithmic scale
// - AM total gain reduction bits 7..4
// - PM total gain reduction bits 3..0
// - manual sensor trim in control 7..3
// - zero trim selects automatic calibration
// - gain field selects five defined gains
// - result bits 7..3 show trim in use
// - bit 2 set when calibration finished
// - bit 1 set when calibration failed
// - mode bit picks adjust result or software code
module frr_regs #(
  parameter int ADDR_W = 12
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // regulator side
  input  wire logic              adjust_done,
  input  wire logic [3:0]        adjust_code,
  input  wire logic              rf_current_limit,
  output logic                   regulator_ext_mode,
  output logic      [3:0]        regulator_code,
  // receiver side
  input  wire logic              rx_start,
  input  wire logic              clear_strength_cmd,
  input  wire logic              am_sample_valid,
  input  wire logic [3:0]        am_sample,
  input  wire logic              pm_sample_valid,
  input  wire logic [3:0]        pm_sample,
  input  wire logic [3:0]        am_gain_cut,
  input  wire logic [3:0]        pm_gain_cut,
  // capacitive sensor side
  input  wire logic              cal_done,
  input  wire logic              cal_fail,
  input  wire logic [4:0]        cal_auto_trim,
  input  wire logic              cal_start,
  output logic      [4:0]        sensor_manual_trim,
  output logic      [2:0]        sensor_gain_select,
  output logic                   sensor_auto_cal
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (ADDR_W < 11) begin : g_bad_addr
    $error("frr_regs: ADDR_W must cover the decoded index bits");
  end

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [3:0]  adj_code;
    logic        ilim;
    logic [7:0]  cap_ctrl;
    logic [7:0]  reg_ctrl;
    logic [4:0]  trim_used;
    logic        cal_end;
    logic        cal_err;
    logic [3:0]  am_cut;
    logic [3:0]  pm_cut;
    logic        clr_pulse;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_mode;
    logic [3:0]  reg_code;
    logic        auto_cal;
  } frr_state_t;

  frr_state_t st;
  frr_state_t next_st;

  logic [3:0] am_peak;
  logic [3:0] pm_peak;
  logic       clear_any;

  // software clear pulse and the command decoder both reset the peaks
  assign clear_any = clear_strength_cmd | st.clr_pulse;

  frr_peak_hold #(.W(4)) u_am_peak (
    .pclk         (pclk),
    .presetn      (presetn),
    .rx_start     (rx_start),
    .clear        (clear_any),
    .sample_valid (am_sample_valid),
    .sample       (am_sample),
    .peak         (am_peak)
  );

  frr_peak_hold #(.W(4)) u_pm_peak (
    .pclk         (pclk),
    .presetn      (presetn),
    .rx_start     (rx_start),
    .clear        (clear_any),
    .sample_valid (pm_sample_valid),
    .sample       (pm_sample),
    .peak         (pm_peak)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [7:0] idx;
    logic       setup;
    logic       wr;
    logic       take;
    logic       mapped;
    logic [7:0] rd;
    logic [7:0] wbyte;
    // address bits above the index make the access unmapped, never an alias
    idx    = (paddr[ADDR_W-1:10] != '0) ? 8'hFF : paddr[9:2];
    setup  = psel && !penable;
    take   = psel && penable && st.pready;
    wr     = take && pwrite && pstrb[0];
    wbyte  = pwdata[7:0];
    mapped = 1'b1;
    rd     = 8'h00;
    next_st = st;
    next_st.clr_pulse = 1'b0;

    // latest adjust result is kept; current limit is a live level
    if (adjust_done) begin
      next_st.adj_code = adjust_code;
    end
    next_st.ilim = rf_current_limit;
    next_st.am_cut = am_gain_cut;
    next_st.pm_cut = pm_gain_cut;

    // calibration flags: a new start clears, the finish event sets and wins
    if (cal_start) begin
      next_st.cal_end = 1'b0;
      next_st.cal_err = 1'b0;
    end
    if (cal_done) begin
      next_st.cal_end   = 1'b1;
      next_st.cal_err   = cal_fail;
      next_st.trim_used = (st.cap_ctrl[7:frr_pkg::TRIM_LSB] == frr_pkg::TRIM_AUTO)
                          ? cal_auto_trim : st.cap_ctrl[7:frr_pkg::TRIM_LSB];
    end

    // reads decode at setup and answer one cycle later; writes land at the access edge
    if (idx == frr_pkg::IDX_REGULATOR_READOUT) begin
      rd = {st.adj_code, 3'b000, st.ilim};
    end else if (idx == frr_pkg::IDX_SIGNAL_STRENGTH_PEAKS) begin
      rd = {am_peak, pm_peak};
    end else if (idx == frr_pkg::IDX_GAIN_REDUCTION_STATE) begin
      rd = {st.am_cut, st.pm_cut};
    end else if (idx == frr_pkg::IDX_CAP_SENSOR_CONTROL) begin
      rd = st.cap_ctrl;
      if (wr) begin
        next_st.cap_ctrl = wbyte;
      end
    end else if (idx == frr_pkg::IDX_CAP_SENSOR_RESULT) begin
      rd = {st.trim_used, st.cal_end, st.cal_err, 1'b0};
    end else if (idx == frr_pkg::IDX_REGULATOR_CONTROL) begin
      rd = {st.reg_ctrl[7:3], 3'b000};
      if (wr) begin
        next_st.reg_ctrl = {wbyte[7:3], 3'b000};
      end
    end else if (idx == frr_pkg::IDX_STRENGTH_COMMAND) begin
      rd = 8'h00;
      if (wr && wbyte[frr_pkg::CLEAR_CMD_BIT]) begin
        next_st.clr_pulse = 1'b1;
      end
    end else begin
      mapped = 1'b0;
    end

    // read-only registers take writes without effect
    next_st.pready  = setup;
    next_st.pslverr = setup && !mapped;
    next_st.prdata  = (setup && !pwrite) ? {24'h000000, rd} : 32'h00000000;

    // regulator source: adjust result or software code
    next_st.ext_mode = next_st.reg_ctrl[frr_pkg::REG_MODE_BIT];
    next_st.reg_code = next_st.ext_mode
                       ? next_st.reg_ctrl[frr_pkg::REG_EXT_LSB+3:frr_pkg::REG_EXT_LSB]
                       : next_st.adj_code;
    // auto flag kept in a flop so the output carries no decode glitch
    next_st.auto_cal = (next_st.cap_ctrl[7:frr_pkg::TRIM_LSB] == frr_pkg::TRIM_AUTO);
  end


  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st          <= '0;
      st.cap_ctrl <= frr_pkg::CAP_CONTROL_RESET;
      st.reg_ctrl <= frr_pkg::REG_CONTROL_RESET;
      st.auto_cal <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flip-flops
  assign prdata             = st.prdata;
  assign pready             = st.pready;
  assign pslverr            = st.pslverr;
  assign regulator_ext_mode = st.ext_mode;
  assign regulator_code     = st.reg_code;
  assign sensor_manual_trim = st.cap_ctrl[7:3];
  assign sensor_gain_select = st.cap_ctrl[2:0];
  assign sensor_auto_cal    = st.auto_cal;

endmodule

// [verification/frr_regs_asserts.sv]
/*
  frr_regs_asserts: concurrent checks on the ports of frr_regs.
  Assumes: single pclk domain, presetn async active low, writes taken at the access edge.
*/
module frr_regs_asserts #(
  parameter int ADDR_W = 12
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              adjust_done,
  input wire logic [3:0]        adjust_code,
  input wire logic              regulator_ext_mode,
  input wire logic [3:0]        regulator_code,
  input wire logic [4:0]        sensor_manual_trim,
  input wire logic [2:0]        sensor_gain_select,
  input wire logic              sensor_auto_cal
);
  // ****************************************************************
  // bus steps and properties
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // a write lands at the access edge with pready high, so effects show one edge later
  sequence s_wr(logic [ADDR_W-1:0] a);
    psel && penable && pready && pwrite && pstrb[0] && paddr == a;
  endsequence
  sequence s_ext;
    s_wr(12'h100) ##0 pwdata[7];
  endsequence

  property p_unmapped;
    psel && !penable && paddr == 12'h0C4 |=> pready && pslverr && prdata == 32'h0;
  endproperty
  property p_upper;
    pready |-> prdata[31:8] == 24'h0;
  endproperty
  property p_trim_wr;
    s_wr(12'h0BC) |=> sensor_manual_trim == $past(pwdata[7:3])
      && sensor_gain_select == $past(pwdata[2:0]);
  endproperty
  property p_trim_hold;
    !(psel && pwrite) |=> $stable(sensor_manual_trim) && $stable(sensor_gain_select);
  endproperty
  property p_auto;
    sensor_auto_cal == (sensor_manual_trim == 5'h00);
  endproperty
  property p_adjust;
    adjust_done && !regulator_ext_mode && !(psel && pwrite)
      |=> regulator_code == $past(adjust_code);
  endproperty
  property p_mode_wr;
    s_wr(12'h100) |=> regulator_ext_mode == $past(pwdata[7]);
  endproperty
  property p_ext_code;
    s_ext |=> regulator_code == $past(pwdata[6:3]);
  endproperty

  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");
  a_upper: assert property (p_upper)
    else $error("upper read bits not zero");
  a_trim_wr: assert property (p_trim_wr)
    else $error("sensor control write not applied");
  a_trim_hold: assert property (p_trim_hold)
    else $error("sensor control changed without write");
  a_auto: assert property (p_auto)
    else $error("auto calibration flag wrong");
  a_adjust: assert property (p_adjust)
    else $error("adjust result not taken");
  a_mode_wr: assert property (p_mode_wr)
    else $error("regulator mode not written");
  a_ext_code: assert property (p_ext_code)
    else $error("software regulator code not used");
endmodule

bind frr_regs frr_regs_asserts #(.ADDR_W(ADDR_W)) u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .adjust_done, .adjust_code,
  .regulator_ext_mode, .regulator_code, .sensor_manual_trim, .sensor_gain_select,
  .sensor_auto_cal);

// [verification/frr_regs_tb.sv]
/*
  frr_regs_tb: directed self-checking bench for frr_regs.
  Assumes: frr_regs_asserts bound alongside, APB slave answers within 20 cycles.
*/
module frr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // stimulus signals
  // ****************************************************************
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0]  pstrb = 4'hF, adjust_code = 4'h0, am_sample = 4'h0, pm_sample = 4'h0;
  logic [3:0]  am_gain_cut = 4'h0, pm_gain_cut = 4'h0, regulator_code;
  logic        pready, pslverr, regulator_ext_mode, sensor_auto_cal;
  logic        adjust_done = 1'b0, rf_current_limit = 1'b0, rx_start = 1'b0;
  logic        clear_strength_cmd = 1'b0, am_sample_valid = 1'b0, pm_sample_valid = 1'b0;
  logic        cal_done = 1'b0, cal_fail = 1'b0, cal_start = 1'b0;
  logic [4:0]  cal_auto_trim = 5'h00, sensor_manual_trim;
  logic [2:0]  sensor_gain_select;
  int          num_errors = 0, tests_run = 0;

  frr_regs DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .adjust_done, .adjust_code, .rf_current_limit, .regulator_ext_mode,
    .regulator_code, .rx_start, .clear_strength_cmd, .am_sample_valid, .am_sample,
    .pm_sample_valid, .pm_sample, .am_gain_cut, .pm_gain_cut, .cal_done, .cal_fail,
    .cal_auto_trim, .cal_start, .sensor_manual_trim, .sensor_gain_select, .sensor_auto_cal);

  // 50 MHz clock
  always #10 pclk = ~pclk;

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one apb transfer; entered just after an edge, leaves one idle edge behind it
  task automatic apb(logic wr, logic [7:0] idx, logic [7:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) num_errors++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(logic [7:0] idx, logic [7:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, idx, d, q, e);
  endtask

  // read and compare; the spare index 8'h31 must answer with an error, no other index may
  task automatic rd(string what, logic [7:0] idx, logic [7:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, idx, 8'h00, q, e);
    check(what, q, {24'h0, exp});
    check("error flag", {31'h0, e}, {31'h0, idx == 8'h31});
  endtask

  task automatic t_regulator();
    adjust_code <= 4'hA;
    adjust_done <= 1'b1;
    rf_current_limit <= 1'b1;
    @(posedge pclk);
    adjust_done <= 1'b0;
    @(posedge pclk);
    rd("readout", frr_pkg::IDX_REGULATOR_READOUT, 8'hA1);
    rf_current_limit <= 1'b0;
    wr(frr_pkg::IDX_REGULATOR_READOUT, 8'h5E);
    rd("readout", frr_pkg::IDX_REGULATOR_READOUT, 8'hA0);
    wr(frr_pkg::IDX_REGULATOR_CONTROL, 8'hA8);
    check("regulator code", 32'(regulator_code), 32'h5);
    check("regulator mode", 32'(regulator_ext_mode), 32'h1);
    rd("regulator control", frr_pkg::IDX_REGULATOR_CONTROL, 8'hA8);
    wr(frr_pkg::IDX_REGULATOR_CONTROL, 8'h00);
    check("regulator code", 32'(regulator_code), 32'hA);
    check("regulator mode", 32'(regulator_ext_mode), 32'h0);
  endtask

  // three samples per channel; the larger ones must win
  task automatic feed();
    logic [3:0] am_s[3] = '{4'h3, 4'h7, 4'h5};
    logic [3:0] pm_s[3] = '{4'h2, 4'h1, 4'h2};
    for (int i = 0; i < 3; i++) begin
      am_sample <= am_s[i];
      pm_sample <= pm_s[i];
      am_sample_valid <= 1'b1;
      pm_sample_valid <= 1'b1;
      @(posedge pclk);
    end
    am_sample_valid <= 1'b0;
    pm_sample_valid <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic t_peaks();
    feed();
    rd("peaks", frr_pkg::IDX_SIGNAL_STRENGTH_PEAKS, 8'h72);
    rx_start <= 1'b1;
    @(posedge pclk);
    rx_start <= 1'b0;
    rd("peaks", frr_pkg::IDX_SIGNAL_STRENGTH_PEAKS, 8'h00);
    feed();
    clear_strength_cmd <= 1'b1;
    @(posedge pclk);
    clear_strength_cmd <= 1'b0;
    rd("peaks", frr_pkg::IDX_SIGNAL_STRENGTH_PEAKS, 8'h00);
    feed();
    wr(frr_pkg::IDX_STRENGTH_COMMAND, 8'h01);
    rd("peaks", frr_pkg::IDX_SIGNAL_STRENGTH_PEAKS, 8'h00);
  endtask

  task automatic t_sensor();
    logic [2:0] g[5] = '{frr_pkg::GAIN_2P8, frr_pkg::GAIN_6P5, frr_pkg::GAIN_1P1,
                         frr_pkg::GAIN_0P5, frr_pkg::GAIN_0P35};
    logic [4:0] t;
    for (int i = 0; i < 5; i++) begin
      t = 5'(i * 7);
      wr(frr_pkg::IDX_CAP_SENSOR_CONTROL, {t, g[i]});
      rd("control", frr_pkg::IDX_CAP_SENSOR_CONTROL, {t, g[i]});
      check("gain", 32'(sensor_gain_select), 32'(g[i]));
      check("auto", 32'(sensor_auto_cal), 32'(t == 5'h00));
    end
    for (int i = 0; i < 2; i++) begin
      wr(frr_pkg::IDX_CAP_SENSOR_CONTROL, i ? 8'h88 : 8'h00);
      cal_auto_trim <= 5'h0B;
      cal_start <= 1'b1;
      @(posedge pclk);
      cal_start <= 1'b0;
      cal_done <= 1'b1;
      cal_fail <= !i;
      @(posedge pclk);
      cal_done <= 1'b0;
      rd("result", frr_pkg::IDX_CAP_SENSOR_RESULT, i ? 8'h8C : 8'h5E);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // main sequence: reset, then each scenario in turn
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("auto", 32'(sensor_auto_cal), 32'h1);
    rd("control", frr_pkg::IDX_CAP_SENSOR_CONTROL, 8'h00);
    t_regulator();
    t_peaks();
    am_gain_cut <= 4'h9;
    pm_gain_cut <= 4'h3;
    @(posedge pclk);
    rd("gain cut", frr_pkg::IDX_GAIN_REDUCTION_STATE, 8'h93);
    t_sensor();
    rd("unmapped", 8'h31, 8'h00);
    results();
  end

  // watchdog: the scenarios need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    results();
  end
endmodule
